/* File: bench/fsr_drive_model.sv */
// Drive-side partner model: presents the floppy drive pins to the bank
module fsr_drive_model
  import fsr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire fsr_pins_t pins_cmd_in,
  output fsr_pins_t pins_out
);
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////////////////////////
  // Pins change one edge after a command, as a drive would
  always_ff @(posedge clk_sys_in)
  begin
    pins_out <= pins_cmd_in;
  end
endmodule // fsr_drive_model

/* File: bench/tb.sv */
// Self-checking bench for the floppy status and drive control bank
module tb
  import fsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic lay = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [1:0] adr = 2'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] rdat, q, b0;
  logic wreq, irq_g, dma_g;
  fsr_pins_t cmd = fsr_pins_t'(11'h7DC);
  fsr_pins_t pins;
  fsr_ctl_t ctl;
  int fails = 0;
  int n_compared = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  fsr_drive_model u_drv (.clk_sys_in(clk_sys_in), .pins_cmd_in(cmd), .pins_out(pins));
  fsr_regs u_dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .layout_two_in(lay), .pins_in(pins),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
    .avs_byteenable_in(be), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .ctl_out(ctl),
    .irq_gated_out(irq_g), .dma_req_gated_out(dma_g));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Holds the request until waitrequest is sampled low
  task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] v, input logic [3:0] e,
    output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    adr <= a;
    rd <= ~w;
    wr <= w;
    wdat <= {24'h0, v};
    be <= e;
    do
    begin
      @(posedge clk_sys_in);
      n++;
    end
    while (wreq !== 1'b0 && n < 20);
    if (n >= 20)
      fails++;
    d = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [1:0] a, output logic [31:0] d);
    acc(1'b0, a, 8'h00, 4'h0, d);
  endtask
  task automatic wrc(input logic [1:0] a, input logic [7:0] v, input logic [3:0] e, input logic [7:0] k);
    logic [31:0] d;
    acc(1'b1, a, v, e, d);
    repeat (4) @(posedge clk_sys_in);
    chk({26'h0, ctl}, {26'h0, ~k[4], ~(k[1:0] == 2'h0 && k[2]), k[3], k[2], k[1:0]});
    chk({30'h0, irq_g, dma_g}, {30'h0, cmd.floppy_irq & k[3] & k[2], cmd.dma_req & k[3] & k[2]});
  endtask
  // Pins pass a model flop, a two-flop synchroniser and the monitor
  task automatic setp(input logic [10:0] p);
    cmd <= fsr_pins_t'(p);
    repeat (6) @(posedge clk_sys_in);
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clk_sys_in);
    chk({26'h0, ctl}, 32'h30);
    reset_n_in <= 1'b1;
    rdr(2'h3, q);
    chk(q, FSR_UNMAPPED_DATA);
    setp(11'h2BB);
    rdr(2'h0, q);
    chk(q, 32'hBD);
    wrc(2'h2, 8'h1C, 4'h1, 8'h1C);
    rdr(2'h1, q);
    chk(q & 32'hE7, 32'hC5);
    rdr(2'h2, q);
    chk(q & 32'hE7, 32'hC5);
    wrc(2'h2, 8'h04, 4'h1, 8'h04);
    wrc(2'h2, 8'h18, 4'h1, 8'h18);
    wrc(2'h2, 8'h1D, 4'h0, 8'h18);
    wrc(2'h0, 8'hFF, 4'hF, 8'h18);
    wrc(2'h2, 8'h0D, 4'h1, 8'h0D);
    rdr(2'h1, q);
    chk(q & 32'hE7, 32'hE4);
    setp(11'h55C);
    rdr(2'h1, b0);
    setp(11'h54C);
    setp(11'h55C);
    rdr(2'h1, q);
    chk(q, b0 ^ 32'h10);
    setp(11'h554);
    setp(11'h55C);
    rdr(2'h1, q);
    chk(q, b0 ^ 32'h18);
    lay <= 1'b1;
    setp(11'h2BB);
    wrc(2'h2, 8'h14, 4'h1, 8'h14);
    rdr(2'h0, q);
    chk(q, 32'hE2);
    rdr(2'h1, q);
    chk(q & 32'h24, 32'h04);
    setp(11'h55C);
    wrc(2'h2, 8'h10, 4'h1, 8'h10);
    rdr(2'h0, q);
    chk(q, 32'h1D);
    rdr(2'h1, q);
    chk(q & 32'h24, 32'h20);
    end_of_test();
  end
  // Whole sequence takes well under a tenth of this span
  initial
  begin
    #100000;
    fails++;
    end_of_test();
  end
endmodule // tb

/* File: rtl/fsr_pkg.sv */
// Package: register map, field positions and carrier types for the floppy status/output bank
package fsr_pkg;
  localparam int unsigned FSR_ADDR_W = 2;
  // Register indices; byte address is four times the index
  localparam logic [1:0] FSR_IDX_MON_A = 2'h0;
  localparam logic [1:0] FSR_IDX_MON_B = 2'h1;
  localparam logic [1:0] FSR_IDX_DRV_CTL = 2'h2;
  // Drive control field positions
  localparam int unsigned FSR_DC_MOTOR_A = 4;
  localparam int unsigned FSR_DC_DMA_INT_EN = 3;
  localparam int unsigned FSR_DC_HOLD_N = 2;
  localparam int unsigned FSR_DC_SEL_HI = 1;
  localparam int unsigned FSR_DC_SEL_LO = 0;
  localparam logic [7:0] FSR_DC_RESET = 8'h00;
  localparam logic [1:0] FSR_SEL_DRIVE_A = 2'h0;
  // Reset images of the monitor registers, per layout
  localparam logic [7:0] FSR_MON_A_RST_L1 = 8'h16;
  localparam logic [7:0] FSR_MON_A_RST_L2 = 8'h00;
  localparam logic [7:0] FSR_MON_B_RST_L1 = 8'hC0;
  localparam logic [7:0] FSR_MON_B_RST_L2 = 8'h63;
  localparam logic [31:0] FSR_UNMAPPED_DATA = 32'h0000_0000;

  // Drive-side pins, as seen by the bank
  typedef struct packed {
    logic step_n;
    logic outer_cylinder_n;
    logic side_n;
    logic index_n;
    logic write_protect_n;
    logic dir;
    logic write_bit_stream_n;
    logic read_bit_stream_n;
    logic write_gate_n;
    logic floppy_irq;
    logic dma_req;
  } fsr_pins_t;

  // Controls driven out of the drive control register
  typedef struct packed {
    logic motor_a_drive_n;
    logic drive_a_select_out_n;
    logic dma_int_en;
    logic controller_hold_n;
    logic [1:0] unit_pick;
  } fsr_ctl_t;
endpackage

/* File: rtl/fsr_regs.sv */
// Floppy pin-monitor status registers and write-only drive control register on Avalon-MM
//
// Our own choice: the Avalon-MM interface to the registers.
module fsr_regs
  import fsr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic layout_two_in,
  input wire fsr_pins_t pins_in,
  input wire logic [FSR_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output fsr_ctl_t ctl_out,
  output logic irq_gated_out,
  output logic dma_req_gated_out
);

  typedef enum logic [1:0] {
    FSR_IDLE = 2'b01,
    FSR_DONE = 2'b10
  } fsr_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: drive-side signals are asynchronous to the bus clock
  fsr_pins_t sync1_reg;
  fsr_pins_t sync2_reg;
  fsr_pins_t prev_reg;
  logic layout_s1_reg;
  logic layout_reg;

  always_ff @(posedge clk_sys_in)
  begin
    sync1_reg <= pins_in;
    sync2_reg <= sync1_reg;
    prev_reg <= sync2_reg;
    layout_s1_reg <= layout_two_in;
    layout_reg <= layout_s1_reg;
  end

  wire fsr_pins_t p = sync2_reg;
  wire wr_rise = p.write_bit_stream_n & ~prev_reg.write_bit_stream_n;
  wire rd_rise = p.read_bit_stream_n & ~prev_reg.read_bit_stream_n;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, answer on the second edge
  fsr_state_t state_reg;
  fsr_state_t state_next;
  wire req = avs_read_in | avs_write_in;
  wire take = (state_reg == FSR_DONE);

  always_comb
  begin
    case (state_reg)
      FSR_IDLE: state_next = req ? FSR_DONE : FSR_IDLE;
      FSR_DONE: state_next = FSR_IDLE;
      default: state_next = FSR_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
      state_reg <= FSR_IDLE;
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive control register and latches
  logic [7:0] dc_reg;
  logic wtog_reg;
  logic rtog_reg;
  logic wlat_reg;
  logic rlat_reg;
  logic glat_reg;
  logic slat_reg;
  wire dc_wr = take & avs_write_in & avs_byteenable_in[0] & (avs_address_in == FSR_IDX_DRV_CTL);

  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      dc_reg <= FSR_DC_RESET;
      wtog_reg <= 1'b0;
      rtog_reg <= 1'b0;
      wlat_reg <= 1'b0;
      rlat_reg <= 1'b0;
      glat_reg <= 1'b0;
      slat_reg <= 1'b0;
    end
    else
    begin
      if (dc_wr)
        dc_reg <= avs_writedata_in[7:0];
      if (wr_rise)
      begin
        wtog_reg <= ~wtog_reg;
        wlat_reg <= ~p.write_bit_stream_n;
      end
      if (rd_rise)
        rtog_reg <= ~rtog_reg;
      // Latched copies sample on each pulse of their own signal
      rlat_reg <= rd_rise ? 1'b1 : rlat_reg;
      glat_reg <= ~p.write_gate_n ? 1'b1 : (dc_wr ? 1'b0 : glat_reg);
      // Set while the pulse is active, so a pulse under a clearing write is kept
      slat_reg <= ~p.step_n ? 1'b1 : (dc_wr ? 1'b0 : slat_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to the drive and host
  wire hold_n = dc_reg[FSR_DC_HOLD_N];
  wire reqs_en = dc_reg[FSR_DC_DMA_INT_EN] & hold_n;
  wire sel_a = (dc_reg[FSR_DC_SEL_HI:FSR_DC_SEL_LO] == FSR_SEL_DRIVE_A);

  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      ctl_out <= '{motor_a_drive_n: 1'b1, drive_a_select_out_n: 1'b1, dma_int_en: 1'b0,
                   controller_hold_n: 1'b0, unit_pick: 2'h0};
      irq_gated_out <= 1'b0;
      dma_req_gated_out <= 1'b0;
    end
    else
    begin
      ctl_out.motor_a_drive_n <= ~dc_reg[FSR_DC_MOTOR_A];
      ctl_out.drive_a_select_out_n <= ~(sel_a & hold_n);
      ctl_out.dma_int_en <= dc_reg[FSR_DC_DMA_INT_EN];
      ctl_out.controller_hold_n <= hold_n;
      ctl_out.unit_pick <= dc_reg[FSR_DC_SEL_HI:FSR_DC_SEL_LO];
      irq_gated_out <= p.floppy_irq & reqs_en;
      dma_req_gated_out <= p.dma_req & reqs_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Monitor images
  wire [7:0] mon_a_l1 = {p.floppy_irq, 1'b0, ~p.step_n, p.outer_cylinder_n, ~p.side_n,
                         p.index_n, p.write_protect_n, p.dir};
  wire [7:0] mon_a_l2 = {p.floppy_irq, p.dma_req, slat_reg, ~p.outer_cylinder_n, p.side_n,
                         ~p.index_n, ~p.write_protect_n, ~p.dir};
  wire [7:0] mon_b_l1 = {2'b11, dc_reg[FSR_DC_SEL_LO], wtog_reg, rtog_reg, p.write_gate_n ? 1'b0 : 1'b1,
                         1'b0, dc_reg[FSR_DC_MOTOR_A]};
  wire [7:0] mon_b_l2 = {2'b01, ctl_out.drive_a_select_out_n, wlat_reg, rlat_reg, glat_reg,
                         2'b11};
  wire [7:0] mon_a = layout_reg ? mon_a_l2 : mon_a_l1;
  wire [7:0] mon_b = layout_reg ? mon_b_l2 : mon_b_l1;
  wire [31:0] rd_word = (avs_address_in == FSR_IDX_MON_A) ? {24'h000000, mon_a} :
                        (avs_address_in == FSR_IDX_MON_B) ? {24'h000000, mon_b} :
                        (avs_address_in == FSR_IDX_DRV_CTL) ? {24'h000000, mon_b} :
                        FSR_UNMAPPED_DATA;

  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      avs_readdata_out <= FSR_UNMAPPED_DATA;
      avs_waitrequest_out <= 1'b1;
    end
    else
    begin
      avs_waitrequest_out <= ~(state_next == FSR_DONE);
      if (req && state_reg == FSR_IDLE)
        avs_readdata_out <= rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  wr_only_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    dc_wr |=> ##1 ctl_out.motor_a_drive_n == ~$past(avs_writedata_in[FSR_DC_MOTOR_A], 2))
    else $error("motor output does not follow control write");
  req_gate_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !dc_reg[FSR_DC_DMA_INT_EN] |=> !irq_gated_out && !dma_req_gated_out)
    else $error("requests escape while disabled");
  hold_rst_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !dc_reg[FSR_DC_HOLD_N] |=> !ctl_out.controller_hold_n)
    else $error("controller not held in reset");
  wtog_edge_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    wr_rise |=> wtog_reg != $past(wtog_reg))
    else $error("write toggle missed an edge");
  a_rsvd_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !layout_reg |-> mon_a[6] == 1'b0)
    else $error("reserved bit set");
  b_rsvd_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !layout_reg |-> mon_b[7:6] == 2'b11 && mon_b[5] == dc_reg[FSR_DC_SEL_LO])
    else $error("monitor B layout one wrong");
  irq_bit_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    mon_a[7] == p.floppy_irq)
    else $error("interrupt bit wrong");
  side_bit_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    layout_reg |-> mon_a[3] == p.side_n)
    else $error("side bit wrong");
  bus_ans_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (req && state_reg == FSR_IDLE) |=> !avs_waitrequest_out)
    else $error("no answer in one cycle");

  ////////////////////////////////////////////////////////////////////////////
  // Per-bit layout checks, control path checks and bus handshake checks

  step_l1_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !layout_reg |-> mon_a[5] == ~p.step_n)
    else $error("step bit wrong in layout one");

  cyl_l1_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !layout_reg |-> mon_a[4] == p.outer_cylinder_n)
    else $error("cylinder bit wrong in layout one");

  mark_l1_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !layout_reg |-> mon_a[2] == p.index_n)
    else $error("marker bit wrong in layout one");

  side_l1_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !layout_reg |-> mon_a[3] == ~p.side_n)
    else $error("side bit wrong in layout one");

  wp_l1_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !layout_reg |-> mon_a[1] == p.write_protect_n)
    else $error("protect bit wrong in layout one");

  dir_l1_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !layout_reg |-> mon_a[0] == p.dir)
    else $error("direction bit wrong in layout one");

  drq_l2_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    layout_reg |-> mon_a[6] == p.dma_req)
    else $error("dma bit wrong in layout two");

  step_set_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !p.step_n |=> slat_reg)
    else $error("step latch missed a pulse");

  step_clr_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    dc_wr && p.step_n |=> !slat_reg)
    else $error("step latch not cleared");

  step_l2_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    layout_reg |-> mon_a[5] == slat_reg)
    else $error("step bit wrong in layout two");

  cyl_l2_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    layout_reg |-> mon_a[4] == ~p.outer_cylinder_n)
    else $error("cylinder bit wrong in layout two");

  mark_l2_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    layout_reg |-> mon_a[2] == ~p.index_n)
    else $error("marker bit wrong in layout two");

  wp_l2_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    layout_reg |-> mon_a[1] == ~p.write_protect_n)
    else $error("protect bit wrong in layout two");

  dir_l2_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    layout_reg |-> mon_a[0] == ~p.dir)
    else $error("direction bit wrong in layout two");

  wtog_l1_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !layout_reg |-> mon_b[4] == wtog_reg)
    else $error("write toggle not shown");

  rtog_edge_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    rd_rise |=> rtog_reg != $past(rtog_reg))
    else $error("read toggle missed an edge");

  rtog_l1_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !layout_reg |-> mon_b[3] == rtog_reg)
    else $error("read toggle not shown");

  gate_l1_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !layout_reg |-> mon_b[2] == ~p.write_gate_n)
    else $error("gate bit wrong in layout one");

  mot_l1_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !layout_reg |-> mon_b[0] == dc_reg[FSR_DC_MOTOR_A] && mon_b[1] == 1'b0)
    else $error("motor bit wrong in layout one");

  dsel_l2_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    layout_reg |-> mon_b[5] == ctl_out.drive_a_select_out_n)
    else $error("select bit wrong in layout two");

  rsvd_l2_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    layout_reg |-> mon_b[7:6] == 2'b01 && mon_b[1:0] == 2'b11)
    else $error("reserved bits wrong in layout two");

  wlat_l2_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    layout_reg |-> mon_b[4] == wlat_reg)
    else $error("write latch not shown");

  wlat_cap_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    wr_rise |=> !wlat_reg)
    else $error("write latch capture wrong");

  rlat_set_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    rd_rise |=> rlat_reg)
    else $error("read latch missed an edge");

  glat_set_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !p.write_gate_n |=> glat_reg)
    else $error("gate latch missed activity");

  latch_l2_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    layout_reg |-> mon_b[3:2] == {rlat_reg, glat_reg})
    else $error("latched bits not shown");

  dc_load_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    dc_wr |=> dc_reg == $past(avs_writedata_in[7:0]))
    else $error("control write not stored");

  dc_keep_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !dc_wr |=> $stable(dc_reg))
    else $error("control register changed without a write");

  motor_out_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    1'b1 |=> ctl_out.motor_a_drive_n == ~$past(dc_reg[FSR_DC_MOTOR_A]))
    else $error("motor output wrong");

  en_out_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    1'b1 |=> ctl_out.dma_int_en == $past(dc_reg[FSR_DC_DMA_INT_EN]))
    else $error("enable output wrong");

  irq_on_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    dc_reg[FSR_DC_DMA_INT_EN] && dc_reg[FSR_DC_HOLD_N] |=> irq_gated_out == $past(p.floppy_irq))
    else $error("interrupt not passed while enabled");

  dma_on_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    dc_reg[FSR_DC_DMA_INT_EN] && dc_reg[FSR_DC_HOLD_N] |=> dma_req_gated_out == $past(p.dma_req))
    else $error("dma request not passed while enabled");

  hold_rel_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    dc_reg[FSR_DC_HOLD_N] |=> ctl_out.controller_hold_n)
    else $error("controller not released");

  pick_out_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    1'b1 |=> ctl_out.unit_pick == $past(dc_reg[FSR_DC_SEL_HI:FSR_DC_SEL_LO]))
    else $error("drive pick output wrong");

  sel_on_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    sel_a && dc_reg[FSR_DC_HOLD_N] |=> !ctl_out.drive_a_select_out_n)
    else $error("drive A not selected");

  sel_rsvd_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !sel_a |=> ctl_out.drive_a_select_out_n)
    else $error("drive A selected by reserved code");

  ctl_rd_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    avs_address_in == FSR_IDX_DRV_CTL |-> rd_word[7:0] == mon_b && rd_word[31:8] == 24'h000000)
    else $error("control offset read wrong");

  wait_rel_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");

  rd_cap_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (req && state_reg == FSR_IDLE) |=> avs_readdata_out == $past(rd_word))
    else $error("read data not captured");

endmodule // fsr_regs
